// ---- hdl/bod_bit_unit.sv ----
// Bit test/set/clear datapath and condition evaluator, purely combinational.
// Assumes operand and flags are stable for the cycle in which they are used.
`timescale 1ns/1ps
module bod_bit_unit
    import bod_pkg::*;
(
    input wire logic [1:0] group,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] operand,
    input wire logic [7:0] flags_in,
    input wire logic [2:0] cond,
    output logic [7:0] result,
    output logic [7:0] flags_new,
    output logic cond_true
);

    logic [7:0] mask;

    always_comb begin
        mask = 8'h01 << bit_sel;
        result = operand;
        flags_new = flags_in;
        unique case (group)
            GRP_TEST: begin
                // Sign and parity keep their old value; both are undefined anyway.
                flags_new[FLAG_Z] = ~|(operand & mask);
                flags_new[FLAG_H] = 1'b1;
                flags_new[FLAG_N] = 1'b0;
            end
            GRP_SET: result = operand | mask;
            GRP_CLEAR: result = operand & ~mask;
            default: result = operand;
        endcase
    end

    always_comb begin
        unique case (cond)
            COND_NOT_ZERO: cond_true = ~flags_in[FLAG_Z];
            COND_ZERO: cond_true = flags_in[FLAG_Z];
            COND_NO_CARRY: cond_true = ~flags_in[FLAG_C];
            COND_CARRY: cond_true = flags_in[FLAG_C];
            COND_PARITY_ODD: cond_true = ~flags_in[FLAG_PV];
            COND_PARITY_EVEN: cond_true = flags_in[FLAG_PV];
            COND_SIGN_POS: cond_true = ~flags_in[FLAG_S];
            COND_SIGN_NEG: cond_true = flags_in[FLAG_S];
        endcase
    end

endmodule : bod_bit_unit

// ---- hdl/bod_decoder.sv ----
// Fetches and executes single-bit test/set/clear and absolute/relative jumps.
// Assumes the core hands over registers and flags stable while busy, and
// that program and data memory answer with valid strobes.
//
// Contract
// - Bit-select field value is the binary index of bit 0 to 7.
// - Register field: 000 B, 001 C, 010 D, 011 E, 100 H, 101 L, 111 A.
// - Clear opcode has top bits 10 instead of 11; drives selected bit to zero.
// - Set/clear keep flags; 2/8 register, 4/15 indirect, 6/23 indexed.
// - Bit test takes 2/8 register, 3/12 indirect, 5/20 indexed.
// - Every jump leaves all flags untouched, taken or not.
// - Conditional absolute jump loads the 16-bit operand only when true; 3/10.
// - Condition codes: not zero, zero, no carry, carry, odd, even, positive, negative.
// - Relative jump: 2/7 when condition fails, 3/12 when taken or unconditional.
// - Relative displacement is signed and added to the address plus 2.
`timescale 1ns/1ps
module bod_decoder
    import bod_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [15:0] start_addr,
    input wire bod_gpr_t gpr,
    input wire logic [15:0] index_reg_one,
    input wire logic [15:0] index_reg_two,
    input wire logic [7:0] flags_in,
    input wire logic prog_valid,
    input wire logic [7:0] prog_byte,
    output logic prog_ready,
    input wire logic mem_rvalid,
    input wire logic [7:0] mem_rdata,
    output bod_mem_req_t mem_req,
    output logic reg_wr_en,
    output logic [2:0] reg_wr_sel,
    output logic [7:0] reg_wr_data,
    output logic flags_wr_en,
    output logic [7:0] flags_out,
    output logic [15:0] program_counter,
    output logic [2:0] m_cycles,
    output logic [4:0] t_states,
    output logic done,
    output logic bad_opcode
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FETCH = 2'h1,
        ST_EXEC = 2'h3,
        ST_MEMRD = 2'h2
    } bod_state_t;

    bod_state_t state_reg;
    logic [7:0] byte_buf [4];
    logic [2:0] fetch_cnt_reg;
    logic [15:0] base_addr_reg;
    logic [7:0] opnd_mem_reg;
    logic opnd_ok_reg;

    logic cap;
    logic fetch_last;
    logic [2:0] fetch_len;
    logic is_idx;
    logic is_bit;
    logic is_abs;
    logic is_rel;
    logic uncond;
    logic bad;
    logic [7:0] op_byte;
    logic [1:0] grp;
    logic [2:0] bit_idx;
    logic [2:0] reg_sel;
    logic mem_opnd;
    logic is_test;
    logic is_setclr;
    logic [15:0] ea;
    logic [7:0] opnd_val;
    logic [2:0] cond_code;
    logic cond_true;
    logic taken;
    logic [7:0] alu_result;
    logic [7:0] flags_new;
    logic need_read;
    logic exec_fire;
    logic [15:0] rel_disp;
    logic [15:0] next_addr;
    logic [2:0] m_next;
    logic [4:0] t_next;

    // Byte capture; an unknown leading byte ends the fetch at once.
    always_comb begin
        cap = prog_valid && prog_ready;
        fetch_len = bod_instr_len((fetch_cnt_reg == 3'h0) ? prog_byte : byte_buf[0]);
        fetch_last = cap && (fetch_len == 3'h0 || fetch_cnt_reg + 3'h1 == fetch_len);
    end

    always_comb begin
        is_idx = byte_buf[0] == OP_INDEX_ONE_PFX || byte_buf[0] == OP_INDEX_TWO_PFX;
        is_bit = is_idx || byte_buf[0] == OP_BIT_PFX;
        is_abs = bod_is_abs(byte_buf[0]);
        is_rel = bod_is_rel(byte_buf[0]);
        uncond = byte_buf[0] == OP_ABS_JUMP || byte_buf[0] == OP_REL_JUMP;
        op_byte = is_idx ? byte_buf[3] : byte_buf[1];
        grp = op_byte[7:6];
        bit_idx = op_byte[5:3];
        reg_sel = op_byte[2:0];
        bad = !(is_bit || is_abs || is_rel) || (is_bit && grp == GRP_ROTATE)
            || (is_idx && byte_buf[1] != OP_BIT_PFX);
        is_test = is_bit && grp == GRP_TEST;
        is_setclr = is_bit && (grp == GRP_SET || grp == GRP_CLEAR);
        mem_opnd = is_bit && (is_idx || reg_sel == REG_MEM);
        if (is_idx) begin
            ea = ((byte_buf[0] == OP_INDEX_ONE_PFX) ? index_reg_one : index_reg_two)
                + bod_sext(byte_buf[2]);
        end else begin
            ea = {gpr.h, gpr.l};
        end
        // Register 110 reads the byte latched in opnd_mem_reg; mem_opnd routes it to memory.
        unique case (reg_sel)
            REG_B: opnd_val = gpr.b;
            REG_C: opnd_val = gpr.c;
            REG_D: opnd_val = gpr.d;
            REG_E: opnd_val = gpr.e;
            REG_H: opnd_val = gpr.h;
            REG_L: opnd_val = gpr.l;
            REG_MEM: opnd_val = opnd_mem_reg;
            REG_A: opnd_val = gpr.a;
        endcase
        cond_code = is_abs ? byte_buf[0][5:3] : {1'b0, byte_buf[0][4:3]};
        taken = uncond || cond_true;
        need_read = mem_opnd && !opnd_ok_reg && !bad;
        exec_fire = state_reg == ST_EXEC && !need_read;
    end

    bod_bit_unit u_bit_unit (
        .group(grp),
        .bit_sel(bit_idx),
        .operand(opnd_val),
        .flags_in(flags_in),
        .cond(cond_code),
        .result(alu_result),
        .flags_new(flags_new),
        .cond_true(cond_true)
    );

    // Next address and timing for the instruction held in the buffer.
    always_comb begin
        rel_disp = bod_sext(byte_buf[1]);
        next_addr = base_addr_reg + {13'h0000, bod_instr_len(byte_buf[0])};
        m_next = M_BIT_REG;
        t_next = T_BIT_REG;
        if (is_abs) begin
            m_next = M_ABS;
            t_next = T_ABS;
            if (taken) begin
                next_addr = {byte_buf[2], byte_buf[1]};
            end
        end else if (is_rel) begin
            m_next = taken ? M_REL_TAKEN : M_REL_SKIP;
            t_next = taken ? T_REL_TAKEN : T_REL_SKIP;
            if (taken) begin
                next_addr = base_addr_reg + REL_ADDR_STEP + rel_disp;
            end
        end else if (is_test && mem_opnd) begin
            m_next = is_idx ? M_TEST_IDX : M_TEST_MEM;
            t_next = is_idx ? T_TEST_IDX : T_TEST_MEM;
        end else if (mem_opnd) begin
            m_next = is_idx ? M_SETCLR_IDX : M_SETCLR_MEM;
            t_next = is_idx ? T_SETCLR_IDX : T_SETCLR_MEM;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (start) state_reg <= ST_FETCH;
                ST_FETCH: if (fetch_last) state_reg <= ST_EXEC;
                ST_EXEC: state_reg <= need_read ? ST_MEMRD : ST_IDLE;
                ST_MEMRD: if (mem_rvalid) state_reg <= ST_EXEC;
            endcase
        end
    end

    // The buffer is not reset: every byte is written before it is decoded.
    always_ff @(posedge core_clk) begin
        if (cap) begin
            byte_buf[fetch_cnt_reg[1:0]] <= prog_byte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_cnt_reg <= 3'h0;
            prog_ready <= 1'b0;
            base_addr_reg <= ADDR_RST;
        end else if (state_reg == ST_IDLE && start) begin
            fetch_cnt_reg <= 3'h0;
            prog_ready <= 1'b1;
            base_addr_reg <= start_addr;
        end else if (cap) begin
            fetch_cnt_reg <= fetch_cnt_reg + 3'h1;
            prog_ready <= !fetch_last;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            opnd_ok_reg <= 1'b0;
            opnd_mem_reg <= 8'h00;
        end else if (state_reg == ST_IDLE) begin
            opnd_ok_reg <= 1'b0;
        end else if (state_reg == ST_MEMRD && mem_rvalid) begin
            opnd_ok_reg <= 1'b1;
            opnd_mem_reg <= mem_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= '0;
        end else begin
            mem_req.rd <= state_reg == ST_EXEC && need_read;
            mem_req.wr <= exec_fire && !bad && is_setclr && mem_opnd;
            mem_req.addr <= ea;
            mem_req.wdata <= alu_result;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_en <= 1'b0;
            reg_wr_sel <= REG_B;
            reg_wr_data <= 8'h00;
            flags_wr_en <= 1'b0;
            flags_out <= 8'h00;
        end else begin
            reg_wr_en <= exec_fire && !bad && is_setclr && !mem_opnd;
            reg_wr_sel <= reg_sel;
            reg_wr_data <= alu_result;
            // Set, clear and jumps never write flags.
            flags_wr_en <= exec_fire && !bad && is_test;
            flags_out <= flags_new;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            bad_opcode <= 1'b0;
            program_counter <= ADDR_RST;
            m_cycles <= 3'h0;
            t_states <= 5'h00;
        end else begin
            done <= exec_fire;
            bad_opcode <= exec_fire && bad;
            if (exec_fire && !bad) begin
                program_counter <= next_addr;
                m_cycles <= m_next;
                t_states <= t_next;
            end
        end
    end

    chk_test_flags: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && !bad_opcode && $past(is_test) |-> flags_wr_en
            && flags_out[FLAG_Z] == !$past(opnd_val[bit_idx]) && flags_out[FLAG_H]
            && !flags_out[FLAG_N] && flags_out[FLAG_C] == $past(flags_in[FLAG_C]))
        else $error("bit test flags wrong");

    chk_clear_bit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr_en && $past(grp) == GRP_CLEAR |->
            (reg_wr_data & (8'h01 << $past(bit_idx))) == 8'h00)
        else $error("clear left bit set");

    chk_setclr_idx_time: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && !bad_opcode && $past(is_setclr) && $past(is_idx) |->
            !flags_wr_en && m_cycles == 3'h6 && t_states == 5'h17)
        else $error("indexed set/clear timing or flags wrong");

    chk_test_mem_time: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && !bad_opcode && $past(is_test) && $past(mem_opnd) && !$past(is_idx) |->
            m_cycles == 3'h3 && t_states == 5'h0C)
        else $error("indirect test timing wrong");

    chk_jump_flags: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && ($past(is_abs) || $past(is_rel)) |-> !flags_wr_en && !reg_wr_en)
        else $error("jump touched flags");

    chk_abs_target: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && !bad_opcode && $past(is_abs) |-> m_cycles == 3'h3 && t_states == 5'h0A
            && program_counter == ($past(taken) ? {$past(byte_buf[2]), $past(byte_buf[1])}
            : $past(base_addr_reg) + 16'h0003))
        else $error("absolute jump target wrong");

    chk_rel_time: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && !bad_opcode && $past(is_rel) && !$past(taken) |->
            m_cycles == 3'h2 && t_states == 5'h07
            && program_counter == $past(base_addr_reg) + 16'h0002)
        else $error("relative skip wrong");

    chk_rel_target: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        done && !bad_opcode && $past(is_rel) && $past(taken) |-> t_states == 5'h0C
            && program_counter == $past(base_addr_reg) + 16'h0002 + $past(rel_disp))
        else $error("relative target wrong");

    chk_mem_operand: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        state_reg == ST_EXEC && need_read |=> mem_req.rd && state_reg == ST_MEMRD
            && mem_req.addr == $past(ea))
        else $error("memory operand not read");

endmodule : bod_decoder

// ---- hdl/bod_pkg.sv ----
// Shared constants, types and helpers for the bit-operation and jump decoder.
// Assumes a little-endian byte stream from program memory and 8-bit data memory.
package bod_pkg;

    // Leading opcode bytes.
    localparam logic [7:0] OP_BIT_PFX = 8'hCB;
    localparam logic [7:0] OP_INDEX_ONE_PFX = 8'hDD;
    localparam logic [7:0] OP_INDEX_TWO_PFX = 8'hFD;
    localparam logic [7:0] OP_ABS_JUMP = 8'hC3;
    localparam logic [7:0] OP_REL_JUMP = 8'h18;

    // Operation field of the final bit-group opcode byte.
    localparam logic [1:0] GRP_ROTATE = 2'h0;
    localparam logic [1:0] GRP_TEST = 2'h1;
    localparam logic [1:0] GRP_CLEAR = 2'h2;
    localparam logic [1:0] GRP_SET = 2'h3;

    // Register field codes.
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_C = 3'h1;
    localparam logic [2:0] REG_D = 3'h2;
    localparam logic [2:0] REG_E = 3'h3;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;

    // Condition field codes.
    localparam logic [2:0] COND_NOT_ZERO = 3'h0;
    localparam logic [2:0] COND_ZERO = 3'h1;
    localparam logic [2:0] COND_NO_CARRY = 3'h2;
    localparam logic [2:0] COND_CARRY = 3'h3;
    localparam logic [2:0] COND_PARITY_ODD = 3'h4;
    localparam logic [2:0] COND_PARITY_EVEN = 3'h5;
    localparam logic [2:0] COND_SIGN_POS = 3'h6;
    localparam logic [2:0] COND_SIGN_NEG = 3'h7;

    // Flag bit positions.
    localparam int FLAG_C = 0;
    localparam int FLAG_N = 1;
    localparam int FLAG_PV = 2;
    localparam int FLAG_H = 4;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 7;

    // Instruction lengths in bytes and the relative-jump base step.
    localparam logic [2:0] LEN_BIT = 3'h2;
    localparam logic [2:0] LEN_IDX = 3'h4;
    localparam logic [2:0] LEN_ABS = 3'h3;
    localparam logic [2:0] LEN_REL = 3'h2;
    localparam logic [15:0] REL_ADDR_STEP = 16'h0002;
    localparam logic [15:0] ADDR_RST = 16'h0000;

    // Machine cycles and clock states per variant.
    localparam logic [2:0] M_BIT_REG = 3'h2;
    localparam logic [4:0] T_BIT_REG = 5'h08;
    localparam logic [2:0] M_TEST_MEM = 3'h3;
    localparam logic [4:0] T_TEST_MEM = 5'h0C;
    localparam logic [2:0] M_TEST_IDX = 3'h5;
    localparam logic [4:0] T_TEST_IDX = 5'h14;
    localparam logic [2:0] M_SETCLR_MEM = 3'h4;
    localparam logic [4:0] T_SETCLR_MEM = 5'h0F;
    localparam logic [2:0] M_SETCLR_IDX = 3'h6;
    localparam logic [4:0] T_SETCLR_IDX = 5'h17;
    localparam logic [2:0] M_ABS = 3'h3;
    localparam logic [4:0] T_ABS = 5'h0A;
    localparam logic [2:0] M_REL_TAKEN = 3'h3;
    localparam logic [4:0] T_REL_TAKEN = 5'h0C;
    localparam logic [2:0] M_REL_SKIP = 3'h2;
    localparam logic [4:0] T_REL_SKIP = 5'h07;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] h;
        logic [7:0] l;
        logic [7:0] a;
    } bod_gpr_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bod_mem_req_t;

    function automatic logic bod_is_abs(input logic [7:0] op);
        return (op == OP_ABS_JUMP) || (op[7:6] == 2'h3 && op[2:0] == 3'h2);
    endfunction : bod_is_abs

    function automatic logic bod_is_rel(input logic [7:0] op);
        return (op == OP_REL_JUMP) || (op[7:5] == 3'h1 && op[2:0] == 3'h0);
    endfunction : bod_is_rel

    // Zero means the leading byte opens no instruction handled here.
    function automatic logic [2:0] bod_instr_len(input logic [7:0] op);
        if (op == OP_BIT_PFX) return LEN_BIT;
        if (op == OP_INDEX_ONE_PFX || op == OP_INDEX_TWO_PFX) return LEN_IDX;
        if (bod_is_abs(op)) return LEN_ABS;
        if (bod_is_rel(op)) return LEN_REL;
        return 3'h0;
    endfunction : bod_instr_len

    function automatic logic [15:0] bod_sext(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction : bod_sext

endpackage : bod_pkg

// ---- tb/test_bod_decoder.sv ----
// Self-checking bench for the bit test/set/clear and jump decoder.
// Assumes the bod_pkg package is compiled first; the bench plays core, program and data memory.
`timescale 1ns/1ps
module test_bod_decoder
    import bod_pkg::*;
;
    `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

    logic core_clk, rst_n, start, prog_valid, prog_ready, mem_rvalid;
    logic [15:0] start_addr, index_reg_one, index_reg_two, program_counter;
    logic [7:0] flags_in, prog_byte, mem_rdata, reg_wr_data, flags_out;
    bod_gpr_t gpr;
    bod_mem_req_t mem_req;
    logic reg_wr_en, flags_wr_en, done, bad_opcode;
    logic [2:0] reg_wr_sel, m_cycles;
    logic [4:0] t_states;

    int miscompares = 0;
    int cmp_count = 0;
    int rg_n, fl_n, wr_n, dn_n;
    logic [2:0] rg_sel, m_v;
    logic [4:0] t_v;
    logic [7:0] rg_data, fl_v, wr_data;
    logic [15:0] rd_addr, wr_addr, nxt_v;
    logic bad_v;
    logic [15:0] base = 16'h1230;
    logic [7:0] mval = 8'h5a;

    bod_decoder dut (.core_clk(core_clk), .rst_n(rst_n), .start(start), .start_addr(start_addr),
        .gpr(gpr), .index_reg_one(index_reg_one), .index_reg_two(index_reg_two),
        .flags_in(flags_in), .prog_valid(prog_valid), .prog_byte(prog_byte),
        .prog_ready(prog_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .mem_req(mem_req), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
        .reg_wr_data(reg_wr_data), .flags_wr_en(flags_wr_en), .flags_out(flags_out),
        .program_counter(program_counter), .m_cycles(m_cycles), .t_states(t_states),
        .done(done), .bad_opcode(bad_opcode));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Outputs are settled by the falling edge; the data memory answers in the same cycle as a read.
    always @(negedge core_clk) begin
        mem_rvalid = mem_req.rd;
        if (mem_req.rd) begin
            rd_addr = mem_req.addr;
            mem_rdata = mval;
        end else begin
            mem_rdata = ~mval;
        end
        if (mem_req.wr) begin
            wr_n++;
            wr_addr = mem_req.addr;
            wr_data = mem_req.wdata;
        end
        if (reg_wr_en) begin
            rg_n++;
            rg_sel = reg_wr_sel;
            rg_data = reg_wr_data;
        end
        if (flags_wr_en) begin
            fl_n++;
            fl_v = flags_out;
        end
        if (done) begin
            dn_n++;
            nxt_v = program_counter;
            m_v = m_cycles;
            t_v = t_states;
            bad_v = bad_opcode;
        end
    end

    function automatic logic [7:0] reg_val(input logic [2:0] r);
        case (r)
            3'h0: return gpr.b;
            3'h1: return gpr.c;
            3'h2: return gpr.d;
            3'h3: return gpr.e;
            3'h4: return gpr.h;
            3'h5: return gpr.l;
            default: return gpr.a;
        endcase
    endfunction : reg_val

    function automatic logic cond_ok(input logic [2:0] cc, input logic [7:0] f);
        case (cc)
            3'h0: return !f[6];
            3'h1: return f[6];
            3'h2: return !f[0];
            3'h3: return f[0];
            3'h4: return !f[2];
            3'h5: return f[2];
            3'h6: return !f[7];
            default: return f[7];
        endcase
    endfunction : cond_ok

    // Runs one instruction of n bytes and waits, bounded, for its completion pulse.
    task automatic run(input logic [7:0] b0, b1, b2, b3, input int n);
        logic [7:0] bs [4];
        int k;
        bs = '{b0, b1, b2, b3};
        rg_n = 0;
        fl_n = 0;
        wr_n = 0;
        dn_n = 0;
        rd_addr = 16'h0000;
        start = 1'b1;
        start_addr = base;
        @(negedge core_clk);
        start = 1'b0;
        for (int i = 0; i < n; i++) begin
            k = 0;
            while (!prog_ready && k < 20) begin
                @(negedge core_clk);
                k++;
            end
            prog_valid = 1'b1;
            prog_byte = bs[i];
            @(negedge core_clk);
        end
        prog_valid = 1'b0;
        k = 0;
        while (dn_n == 0 && k < 50) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
        `CHK(dn_n, 1)
    endtask : run

    task automatic t_bit_reg();
        logic [7:0] f, v;
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 8; b++) begin
                if (r != 6) begin
                    flags_in = b[0] ? 8'h83 : 8'h14;
                    run(OP_BIT_PFX, {2'b01, 3'(b), 3'(r)}, 8'h00, 8'h00, 2);
                    f = flags_in;
                    v = reg_val(3'(r));
                    f[6] = ~v[b];
                    f[4] = 1'b1;
                    f[1] = 1'b0;
                    `CHK(fl_n, 1)
                    `CHK(fl_v, f)
                    `CHK(rg_n, 0)
                    `CHK({m_v, t_v}, {3'h2, 5'h08})
                    `CHK(nxt_v, base + 16'h0002)
                end
            end
        end
        $display("test bit_reg done");
    endtask : t_bit_reg

    task automatic t_setclr_reg();
        logic [7:0] v;
        for (int op = 2; op < 4; op++) begin
            for (int r = 0; r < 8; r++) begin
                for (int b = 0; b < 8; b++) begin
                    if (r != 6) begin
                        run(OP_BIT_PFX, {2'(op), 3'(b), 3'(r)}, 8'h00, 8'h00, 2);
                        v = reg_val(3'(r));
                        v[b] = op[0];
                        `CHK(rg_n, 1)
                        `CHK(rg_sel, 3'(r))
                        `CHK(rg_data, v)
                        `CHK(fl_n, 0)
                        `CHK({m_v, t_v}, {3'h2, 5'h08})
                    end
                end
            end
        end
        $display("test setclr_reg done");
    endtask : t_setclr_reg

    task automatic t_mem();
        flags_in = 8'h01;
        run(OP_BIT_PFX, 8'h5e, 8'h00, 8'h00, 2);
        `CHK(rd_addr, 16'h1234)
        `CHK(fl_v, 8'h11)
        `CHK({m_v, t_v, nxt_v}, {3'h3, 5'h0c, base + 16'h0002})
        run(OP_BIT_PFX, 8'hfe, 8'h00, 8'h00, 2);
        `CHK({wr_n, rg_n, fl_n}, {32'd1, 32'd0, 32'd0})
        `CHK({wr_addr, wr_data}, {16'h1234, 8'hda})
        `CHK({m_v, t_v}, {3'h4, 5'h0f})
        run(OP_INDEX_ONE_PFX, OP_BIT_PFX, 8'h05, 8'h56, 4);
        `CHK(rd_addr, 16'h4005)
        `CHK(fl_v, 8'h51)
        `CHK({m_v, t_v, nxt_v}, {3'h5, 5'h14, base + 16'h0004})
        run(OP_INDEX_TWO_PFX, OP_BIT_PFX, 8'hf0, 8'hb6, 4);
        `CHK({rd_addr, wr_addr, wr_data}, {16'h7ff8, 16'h7ff8, 8'h1a})
        `CHK({m_v, t_v, nxt_v}, {3'h6, 5'h17, base + 16'h0004})
        `CHK(fl_n, 0)
        $display("test mem done");
    endtask : t_mem

    task automatic t_jumps();
        logic ok;
        for (int i = 0; i < 2; i++) begin
            flags_in = i[0] ? 8'hc5 : 8'h00;
            for (int cc = 0; cc < 8; cc++) begin
                run({2'b11, 3'(cc), 3'b010}, 8'h34, 8'h12, 8'h00, 3);
                ok = cond_ok(3'(cc), flags_in);
                `CHK(nxt_v, ok ? 16'h1234 : base + 16'h0003)
                `CHK({m_v, t_v}, {3'h3, 5'h0a})
                `CHK({fl_n, rg_n}, {32'd0, 32'd0})
            end
            for (int cc = 0; cc < 4; cc++) begin
                run({3'b001, 2'(cc), 3'b000}, 8'hf6, 8'h00, 8'h00, 2);
                ok = cond_ok(3'(cc), flags_in);
                `CHK(nxt_v, ok ? base - 16'h0008 : base + 16'h0002)
                `CHK({m_v, t_v}, ok ? {3'h3, 5'h0c} : {3'h2, 5'h07})
                `CHK({fl_n, rg_n}, {32'd0, 32'd0})
            end
        end
        run(OP_ABS_JUMP, 8'hcd, 8'hab, 8'h00, 3);
        `CHK({nxt_v, m_v, t_v}, {16'habcd, 3'h3, 5'h0a})
        run(OP_REL_JUMP, 8'h7f, 8'h00, 8'h00, 2);
        `CHK({nxt_v, m_v, t_v}, {base + 16'h0081, 3'h3, 5'h0c})
        `CHK(fl_n, 0)
        $display("test jumps done");
    endtask : t_jumps

    task automatic t_bad();
        logic [15:0] prev;
        prev = program_counter;
        run(OP_BIT_PFX, 8'h00, 8'h00, 8'h00, 2);
        `CHK({bad_v, nxt_v}, {1'b1, prev})
        `CHK({rg_n, fl_n, wr_n}, {32'd0, 32'd0, 32'd0})
        $display("test bad done");
    endtask : t_bad

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // The whole suite needs about a thousand cycles; this span of 25000 cycles leaves ample margin.
    initial begin
        #200000;
        miscompares++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        start_addr = 16'h0000;
        prog_valid = 1'b0;
        prog_byte = 8'h00;
        flags_in = 8'h00;
        index_reg_one = 16'h4000;
        index_reg_two = 16'h8008;
        gpr = '{b: 8'h5a, c: 8'ha5, d: 8'h0f, e: 8'hf0, h: 8'h12, l: 8'h34, a: 8'hc3};
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK({program_counter, done, reg_wr_en}, {16'h0000, 1'b0, 1'b0})
        t_bit_reg();
        t_setclr_reg();
        t_mem();
        t_jumps();
        t_bad();
        close_out();
    end
endmodule : test_bod_decoder
